// ---- logic/pix_out_pkg.sv ----
package pix_out_pkg;
  // -----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // -----------------------------------------------------------------
  localparam logic [7:0] IDX_RSVD_A   = 8'h60;
  localparam logic [7:0] IDX_RSVD_B   = 8'h61;
  localparam logic [7:0] IDX_LANE_PWR = 8'h70;
  localparam logic [7:0] IDX_BLACK    = 8'h80;
  localparam logic [7:0] IDX_CFG      = 8'h81;
  localparam logic [7:0] IDX_TRAIN    = 8'h82;
  localparam logic [7:0] IDX_CAL_ERR  = 8'h88;
  localparam logic [7:0] IDX_CHKSUM   = 8'h89;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h8A;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h8B;

  // -----------------------------------------------------------------
  // Reset values
  // -----------------------------------------------------------------
  localparam logic [15:0] RST_LANE_PWR = 16'h0000;
  localparam logic [15:0] RST_BLACK    = 16'h4008;
  localparam logic [15:0] RST_CFG      = 16'hC001;
  localparam logic [15:0] RST_TRAIN    = 16'h03A6;

  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int BIT_CLK_PWR  = 0;
  localparam int BIT_SYNC_PWR = 1;
  localparam int BIT_DATA_PWR = 2;
  localparam int TGT_MSB      = 7;
  localparam int EXP_LSB      = 8;
  localparam int EXP_MSB      = 10;
  localparam int BIT_SEED     = 15;
  localparam int BIT_AUTO     = 0;
  localparam int MAN_LSB      = 1;
  localparam int MAN_MSB      = 9;
  localparam int BIT_NEG      = 10;
  localparam int BIT_NARROW   = 13;
  localparam int TRAIN_MSB    = 9;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_ERR      = 1;

  // -----------------------------------------------------------------
  // Structure and timing
  // -----------------------------------------------------------------
  localparam int NUM_CH    = 4;
  localparam int WORD_W    = 10;
  localparam int WIN_SHIFT = 4;
  localparam logic [3:0] LAST_BIT_WIDE   = 4'h9;
  localparam logic [3:0] LAST_BIT_NARROW = 4'h7;
endpackage

// ---- logic/pix_out_path.sv ----
`timescale 1ns/1ps
// Summary of operation
// [R1] Clock lane follows its power bit, off at reset
// [R2] Sync lane follows its power bit, off at reset
// [R3] Four data lanes follow one power bit
// [R4] Output black sits at 8-bit target
// [R5] Calibration averages two-to-exponent black samples
// [R6] Checksum starts all zeros or all ones
// [R7] Auto calibration on by default, bypassable
// [R8] Manual value replaces auto correction when off
// [R9] Manual value added, or subtracted when negated
// [R10] Narrow words; window indication delayed four bits
// [R11] Idle data lanes carry training word
// [R12] Receiver aligns words on training word
// [R13] Per-channel flag when black samples insufficient
// [R14] Auto correction: channel average toward target
module pix_out_path (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pixel source
  input  wire logic        pix_valid_i,
  input  wire logic [39:0] pix_data_i,
  input  wire logic [3:0]  pix_black_i,
  input  wire logic        pix_win_i,
  input  wire logic        frame_start_i,
  input  wire logic        black_end_i,
  output logic             pix_ready_o,
  // Serial link
  input  wire logic        link_clk_i,
  output logic             clk_lane_o,
  output logic             sync_lane_o,
  output logic [3:0]       data_lane_o,
  // Interrupt
  output logic             irq_o
);
  localparam int NCH = pix_out_pkg::NUM_CH;
  localparam int WW  = pix_out_pkg::WORD_W;

  logic [15:0] lane_pwr_ff, black_ff, cfg_ff, train_ff;
  logic [1:0]  irq_stat_ff, irq_mask_ff;
  logic [WW-1:0] chk_ff;
  logic [NCH-1:0] err_ff, done_ff;
  logic [16:0] acc_ff [NCH];
  logic [8:0]  cnt_ff [NCH];
  logic [WW-1:0] avg_ff [NCH];
  logic [WW-1:0] shift_ff [NCH];
  logic [WW-1:0] sync_sr_ff;
  logic [pix_out_pkg::WIN_SHIFT-1:0] win_dly_ff;
  logic [3:0]  bit_cnt_ff;
  logic        link_s1_ff, link_s2_ff, link_prev_ff;
  logic        ack_ff;

  // -----------------------------------------------------------------
  // Register bus
  // -----------------------------------------------------------------
  logic [7:0]  idx;
  logic        wr_acc;
  logic [15:0] wmask;
  logic [15:0] wdat;
  assign idx    = wb_adr_i[9:2];
  assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff; // Lands at the ack edge
  assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat   = wb_dat_i[15:0];

  // One wait state, ack drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end
  assign wb_ack_o = ack_ff;

  // Read data registered with the ack; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
      unique case (idx)
        pix_out_pkg::IDX_LANE_PWR: wb_dat_o <= {16'h0000, lane_pwr_ff};
        pix_out_pkg::IDX_BLACK:    wb_dat_o <= {16'h0000, black_ff};
        pix_out_pkg::IDX_CFG:      wb_dat_o <= {16'h0000, cfg_ff};
        pix_out_pkg::IDX_TRAIN:    wb_dat_o <= {16'h0000, train_ff};
        pix_out_pkg::IDX_CAL_ERR:  wb_dat_o <= {28'h0000000, err_ff};
        pix_out_pkg::IDX_CHKSUM:   wb_dat_o <= {22'h000000, chk_ff};
        pix_out_pkg::IDX_IRQ_STAT: wb_dat_o <= {30'h00000000, irq_stat_ff};
        pix_out_pkg::IDX_IRQ_MASK: wb_dat_o <= {30'h00000000, irq_mask_ff};
        default:                   wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_pwr_ff <= pix_out_pkg::RST_LANE_PWR; // see [R1] see [R2] see [R3]
      black_ff    <= pix_out_pkg::RST_BLACK;
      cfg_ff      <= pix_out_pkg::RST_CFG;      // see [R7]
      train_ff    <= pix_out_pkg::RST_TRAIN;
      irq_mask_ff <= 2'h0;
    end else if (wr_acc) begin
      unique case (idx)
        pix_out_pkg::IDX_LANE_PWR: lane_pwr_ff <= (lane_pwr_ff & ~wmask) | (wdat & wmask);
        pix_out_pkg::IDX_BLACK:    black_ff    <= (black_ff & ~wmask) | (wdat & wmask);
        pix_out_pkg::IDX_CFG:      cfg_ff      <= (cfg_ff & ~wmask) | (wdat & wmask);
        pix_out_pkg::IDX_TRAIN:    train_ff    <= (train_ff & ~wmask) | (wdat & wmask);
        pix_out_pkg::IDX_IRQ_MASK: if (wb_sel_i[0]) irq_mask_ff <= wdat[1:0];
        default: ;
      endcase
    end
  end

  // Field views
  logic       clk_pwr, sync_pwr, data_pwr, seed, auto_en, neg, narrow;
  logic [7:0] tgt;
  logic [2:0] smp_exp;
  logic [8:0] man;
  assign clk_pwr  = lane_pwr_ff[pix_out_pkg::BIT_CLK_PWR];
  assign sync_pwr = lane_pwr_ff[pix_out_pkg::BIT_SYNC_PWR];
  assign data_pwr = lane_pwr_ff[pix_out_pkg::BIT_DATA_PWR];
  assign tgt      = black_ff[pix_out_pkg::TGT_MSB:0];
  assign smp_exp  = black_ff[pix_out_pkg::EXP_MSB:pix_out_pkg::EXP_LSB];
  assign seed     = black_ff[pix_out_pkg::BIT_SEED];
  assign auto_en  = cfg_ff[pix_out_pkg::BIT_AUTO];
  assign man      = cfg_ff[pix_out_pkg::MAN_MSB:pix_out_pkg::MAN_LSB];
  assign neg      = cfg_ff[pix_out_pkg::BIT_NEG];
  assign narrow   = cfg_ff[pix_out_pkg::BIT_NARROW];

  // -----------------------------------------------------------------
  // Link clock sampling
  // -----------------------------------------------------------------
  // Two flops before use; the edge is found on the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_s1_ff   <= 1'b0;
      link_s2_ff   <= 1'b0;
      link_prev_ff <= 1'b0;
    end else begin
      link_s1_ff   <= link_clk_i;
      link_s2_ff   <= link_s1_ff;
      link_prev_ff <= link_s2_ff;
    end
  end

  logic bit_en, last_bit, load_en, take;
  assign bit_en   = link_s2_ff && !link_prev_ff;
  // At or past the end, so a mode switch mid-slot cannot run the counter round
  assign last_bit = bit_cnt_ff >= (narrow ? pix_out_pkg::LAST_BIT_NARROW
                                          : pix_out_pkg::LAST_BIT_WIDE); // see [R10]
  assign load_en  = bit_en && last_bit;
  // Powered-down data lanes stall the source instead of dropping words
  assign pix_ready_o = load_en && data_pwr;
  assign take        = pix_ready_o && pix_valid_i;

  // -----------------------------------------------------------------
  // Black correction
  // -----------------------------------------------------------------
  logic signed [12:0] corr_v [NCH];
  logic [WW-1:0]      corr   [NCH];
  logic [WW-1:0]      px     [NCH];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      px[c] = pix_data_i[c*WW +: WW];
      if (auto_en) begin
        // Average removed, target added back
        corr_v[c] = $signed({3'b000, px[c]}) - $signed({3'b000, avg_ff[c]})
                    + $signed({5'b00000, tgt}); // see [R4] see [R14] see [R7]
      end else if (neg) begin
        corr_v[c] = $signed({3'b000, px[c]}) - $signed({4'b0000, man}); // see [R8] see [R9]
      end else begin
        corr_v[c] = $signed({3'b000, px[c]}) + $signed({4'b0000, man}); // see [R9]
      end
      // Clamp so that wrap never turns black into white
      if (corr_v[c] < 0) begin
        corr[c] = 10'h000;
      end else if (corr_v[c] > 13'sh03FF) begin
        corr[c] = 10'h3FF;
      end else begin
        corr[c] = corr_v[c][WW-1:0];
      end
    end
  end

  // Per-channel black sample accumulation
  logic [8:0] need;
  logic [NCH-1:0] done_evt, err_evt;
  assign need = 9'h001 << smp_exp; // see [R5]
  // A frame start discards the sample, so no done event either
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      done_evt[c] = take && pix_black_i[c] && !done_ff[c] && !frame_start_i
                    && (cnt_ff[c] + 9'h001 == need);
      err_evt[c]  = black_end_i && !done_ff[c]; // see [R13]
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_ff <= '0;
      for (int c = 0; c < NCH; c++) begin
        acc_ff[c] <= 17'h00000;
        cnt_ff[c] <= 9'h000;
        avg_ff[c] <= 10'h000;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (frame_start_i) begin
          acc_ff[c]  <= 17'h00000;
          cnt_ff[c]  <= 9'h000;
          done_ff[c] <= 1'b0;
        end else if (take && pix_black_i[c] && !done_ff[c]) begin
          acc_ff[c] <= acc_ff[c] + {7'h00, px[c]};
          cnt_ff[c] <= cnt_ff[c] + 9'h001;
          if (done_evt[c]) begin
            done_ff[c] <= 1'b1;
            avg_ff[c]  <= 10'((acc_ff[c] + {7'h00, px[c]}) >> smp_exp); // see [R5] see [R14]
          end
        end
      end
    end
  end
  // Error flags: a shortfall wins over the frame clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_ff <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (err_evt[c]) begin
          err_ff[c] <= 1'b1; // see [R13]
        end else if (frame_start_i) begin
          err_ff[c] <= 1'b0;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Checksum
  // -----------------------------------------------------------------
  logic [WW-1:0] word_sum;
  always_comb begin
    word_sum = chk_ff;
    for (int c = 0; c < NCH; c++) begin
      word_sum = word_sum + corr[c];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_ff <= 10'h000;
    end else if (frame_start_i) begin
      chk_ff <= seed ? 10'h3FF : 10'h000; // see [R6]
    end else if (take) begin
      chk_ff <= word_sum;
    end
  end

  // -----------------------------------------------------------------
  // Serialisers
  // -----------------------------------------------------------------
  // Words go out MSB first; narrow mode sends the top eight bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt_ff <= 4'h0;
      sync_sr_ff <= 10'h000;
      for (int c = 0; c < NCH; c++) begin
        shift_ff[c] <= 10'h000;
      end
    end else if (bit_en) begin
      if (last_bit) begin
        bit_cnt_ff <= 4'h0;
        sync_sr_ff <= {take && pix_win_i, 9'h000};
        for (int c = 0; c < NCH; c++) begin
          // Idle slots carry the alignment word for the receiver
          shift_ff[c] <= take ? corr[c] : train_ff[pix_out_pkg::TRAIN_MSB:0]; // see [R11]
        end
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        sync_sr_ff <= {sync_sr_ff[WW-2:0], 1'b0};
        for (int c = 0; c < NCH; c++) begin
          shift_ff[c] <= {shift_ff[c][WW-2:0], 1'b0};
        end
      end
    end
  end
  // Window indication delayed by four bit times
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_dly_ff <= '0;
    end else if (bit_en) begin
      win_dly_ff <= {win_dly_ff[pix_out_pkg::WIN_SHIFT-2:0], sync_sr_ff[WW-1]}; // see [R10]
    end
  end
  // Lane drivers held low while powered down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_lane_o  <= 1'b0;
      sync_lane_o <= 1'b0;
      data_lane_o <= 4'h0;
    end else begin
      clk_lane_o  <= clk_pwr && link_s2_ff; // see [R1]
      sync_lane_o <= sync_pwr && (narrow ? win_dly_ff[pix_out_pkg::WIN_SHIFT-1]
                                         : sync_sr_ff[WW-1]); // see [R2] see [R10]
      for (int c = 0; c < NCH; c++) begin
        data_lane_o[c] <= data_pwr && shift_ff[c][WW-1]; // see [R3]
      end
    end
  end

  // -----------------------------------------------------------------
  // Interrupts
  // -----------------------------------------------------------------
  logic [1:0] irq_evt, irq_clr;
  assign irq_evt = {|err_evt, |done_evt};
  assign irq_clr = (wr_acc && idx == pix_out_pkg::IDX_IRQ_STAT && wb_sel_i[0]) ? wdat[1:0]
                                                                                : 2'h0;
  // New events beat a simultaneous write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= 2'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !ack_ff;
  endsequence
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");
  a_clk_lane_off: assert property (@(posedge clk_i) disable iff (rst_i) // see [R1]
    !clk_pwr |=> !clk_lane_o)
    else $error("clock lane active while powered down");
  a_sync_lane_off: assert property (@(posedge clk_i) disable iff (rst_i) // see [R2]
    !sync_pwr |=> !sync_lane_o)
    else $error("sync lane active while powered down");
  a_data_lane_off: assert property (@(posedge clk_i) disable iff (rst_i) // see [R3]
    !data_pwr |=> data_lane_o == 4'h0)
    else $error("data lanes active while powered down");
  a_train_idle: assert property (@(posedge clk_i) disable iff (rst_i) // see [R11]
    load_en && !take |=> shift_ff[0] == $past(train_ff[9:0]))
    else $error("idle slot did not load training word");
  a_seed_start: assert property (@(posedge clk_i) disable iff (rst_i) // see [R6]
    frame_start_i |=> chk_ff == ($past(seed) ? 10'h3FF : 10'h000))
    else $error("checksum seed wrong");
  a_error_flag: assert property (@(posedge clk_i) disable iff (rst_i) // see [R13]
    black_end_i && !done_ff[0] |=> err_ff[0] && irq_stat_ff[1])
    else $error("calibration shortfall not flagged");
  a_manual_sub: assert property (@(posedge clk_i) disable iff (rst_i) // see [R9]
    take && !auto_en && neg && px[0] >= {1'b0, man} |=>
      shift_ff[0] == $past(px[0] - {1'b0, man}))
    else $error("manual subtraction wrong");
  a_narrow_len: assert property (@(posedge clk_i) disable iff (rst_i) // see [R10]
    narrow && bit_en && bit_cnt_ff == 4'h7 |=> bit_cnt_ff == 4'h0)
    else $error("narrow word length wrong");
endmodule // pix_out_path

// ---- logic/unused_placeholder_none.sv ----
`timescale 1ns/1ps

// ---- testbench/lane_rx_model.sv ----
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Receiver model: deserialises each data lane, locks on idle word
// -----------------------------------------------------------------
module lane_rx_model (
  // Link side
  input  wire logic        link_clk_i,
  input  wire logic [3:0]  data_lane_i,
  input  wire logic [9:0]  train_i,
  // Received words
  output logic [3:0]       locked_o,
  output logic [39:0]      word_o,
  output logic [7:0]       data_cnt_o
);
  logic [9:0] sh_ff  [4];
  logic [3:0] pos_ff [4];
  logic [9:0] train_ff;

  initial begin
    locked_o   = '0;
    word_o     = '0;
    data_cnt_o = '0;
    train_ff   = '0;
  end

  // Sample on link rising edge; bit has stood more than half a period by then
  always @(posedge link_clk_i) begin
    logic [9:0] s;
    train_ff <= train_i;
    for (int c = 0; c < 4; c++) begin
      s = {sh_ff[c][8:0], data_lane_i[c]};
      sh_ff[c] <= s;
      if (train_i != train_ff) begin
        locked_o[c] <= 1'b0; // New idle word forces a fresh search
      end else if (!locked_o[c]) begin
        if (s == train_i) begin
          locked_o[c] <= 1'b1;
          pos_ff[c]   <= 4'h0;
        end
      end else if (pos_ff[c] == 4'h9) begin
        pos_ff[c] <= 4'h0;
        if (s != train_i) begin
          word_o[c*10 +: 10] <= s;
          if (c == 0) data_cnt_o <= data_cnt_o + 8'h01;
        end
      end else begin
        pos_ff[c] <= pos_ff[c] + 4'h1;
      end
    end
  end
endmodule // lane_rx_model

// ---- testbench/pix_out_path_tb.sv ----
`timescale 1ns/1ps
module pix_out_path_tb;
  logic clk_i = 0, rst_i = 1, link_clk = 0;
  logic wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
  logic [9:0]  wb_adr = '0;
  logic [3:0]  wb_sel = '0;
  logic [31:0] wb_dat_w = '0, wb_dat_r;
  logic pix_valid = 0, pix_win = 0, frame_start = 0, black_end = 0;
  logic [39:0] pix_data = '0, rx_word;
  logic [3:0]  pix_black = '0, data_lane, locked;
  logic pix_ready, clk_lane, sync_lane, irq, sync_seen = 0;
  logic [9:0]  train_w = 10'h3A6;
  logic [7:0]  rx_cnt;
  int error_cnt = 0, n_tests = 0;

  always #12.5 clk_i = ~clk_i;
  always #100 link_clk = ~link_clk;
  // Sticky record of window flag on the sync lane
  always @(posedge clk_i) if (sync_lane) sync_seen <= 1'b1;

  pix_out_path DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .pix_valid_i(pix_valid), .pix_data_i(pix_data),
    .pix_black_i(pix_black), .pix_win_i(pix_win), .frame_start_i(frame_start),
    .black_end_i(black_end), .pix_ready_o(pix_ready), .link_clk_i(link_clk),
    .clk_lane_o(clk_lane), .sync_lane_o(sync_lane), .data_lane_o(data_lane), .irq_o(irq));
  lane_rx_model rx (.link_clk_i(link_clk), .data_lane_i(data_lane), .train_i(train_w),
    .locked_o(locked), .word_o(rx_word), .data_cnt_o(rx_cnt));

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // Classic cycle: hold until ack sampled, then release
  task wb(input logic w, input logic [7:0] idx, input logic [15:0] d, output logic [31:0] q);
    int k;
    @(posedge clk_i);
    wb_cyc <= 1; wb_stb <= 1; wb_we <= w; wb_sel <= 4'h3;
    wb_adr <= {idx, 2'b00}; wb_dat_w <= {16'h0000, d};
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack !== 1'b1 && k < 50);
    q = wb_dat_r;
    wb_cyc <= 0; wb_stb <= 0; wb_we <= 0;
    if (k >= 50) chk("wb_ack", 1, 0);
  endtask
  task wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
    // Write lands at the ack edge; let it settle before looking
    @(posedge clk_i);
  endtask
  task rdc(input string what, input logic [7:0] idx, input logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 16'h0000, q);
    chk(what, {16'h0000, e}, q);
  endtask
  task pulse(input logic be);
    @(posedge clk_i);
    if (be) black_end <= 1; else frame_start <= 1;
    @(posedge clk_i);
    black_end <= 0; frame_start <= 0;
  endtask
  // Offer one group and wait for the next word the receiver cuts
  task send(input logic [9:0] p, input logic [3:0] blk, input logic win,
            output logic [39:0] w);
    int k;
    logic [7:0] n;
    n = rx_cnt;
    @(posedge clk_i);
    pix_valid <= 1; pix_data <= {4{p}}; pix_black <= blk; pix_win <= win;
    k = 0;
    do begin @(posedge clk_i); k++; end while (pix_ready !== 1'b1 && k < 400);
    pix_valid <= 0; pix_black <= 0; pix_win <= 0;
    k = 0;
    while (rx_cnt == n && k < 1500) begin @(posedge clk_i); k++; end
    if (k >= 1500) chk("rx_word", 1, 0);
    w = rx_word;
  endtask
  task chk_px(input logic [9:0] e, input logic [39:0] w);
    chk("lane0 word", {22'h0, e}, {22'h0, w[9:0]});
    chk("lane3 word", {22'h0, e}, {22'h0, w[39:30]});
  endtask
  task wait_lock;
    int k;
    k = 0;
    while (locked !== 4'hF && k < 4000) begin @(posedge clk_i); k++; end
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task t_reset;
    int rdy, act;
    rdc("lane_power", 8'h70, 16'h0000);
    rdc("black_setup", 8'h80, 16'h4008);
    rdc("path_config", 8'h81, 16'hC001);
    rdc("idle_word", 8'h82, 16'h03A6);
    wr(8'h60, 16'hFFFF);
    rdc("reserved_a", 8'h60, 16'h0000);
    rdc("unmapped", 8'h95, 16'h0000);
    rdy = 0; act = 0;
    repeat (200) begin
      @(posedge clk_i);
      rdy += pix_ready;
      act += clk_lane | sync_lane | (|data_lane);
    end
    chk("ready while off", 0, rdy);
    chk("lanes while off", 0, act);
    $display("test reset done");
  endtask
  task t_lanes;
    int tg;
    logic prev;
    logic [39:0] w;
    wr(8'h70, 16'h0001);
    tg = 0;
    prev = clk_lane;
    repeat (100) begin
      @(posedge clk_i);
      tg += (clk_lane != prev);
      prev = clk_lane;
    end
    chk("clock lane runs", 1, tg > 2);
    wr(8'h70, 16'h0007);
    wait_lock();
    chk("lock on idle", 4'hF, locked);
    train_w <= 10'h2C7;
    wr(8'h82, 16'h02C7);
    repeat (300) @(posedge clk_i);
    wait_lock();
    chk("lock on new idle", 4'hF, locked);
    send(10'd100, 4'h0, 1'b1, w);
    chk_px(10'd108, w);
    chk("window on sync", 1, sync_seen);
    $display("test lanes done");
  endtask
  task t_manual;
    logic [39:0] w;
    wr(8'h81, 16'h000A);
    send(10'd100, 4'h0, 1'b0, w);
    chk_px(10'd105, w);
    wr(8'h81, 16'h040A);
    send(10'd100, 4'h0, 1'b0, w);
    chk_px(10'd95, w);
    $display("test manual done");
  endtask
  task t_auto;
    logic [39:0] w;
    wr(8'h81, 16'hC001);
    wr(8'h80, 16'h4110);
    pulse(1'b0);
    send(10'd20, 4'hF, 1'b0, w);
    send(10'd24, 4'hF, 1'b0, w);
    send(10'd100, 4'h0, 1'b0, w);
    chk_px(10'd94, w);
    rdc("done status", 8'h8A, 16'h0001);
    chk("irq masked", 0, irq);
    wr(8'h8B, 16'h0001);
    chk("irq raised", 1, irq);
    wr(8'h8A, 16'h0001);
    chk("irq cleared", 0, irq);
    wr(8'h80, 16'hC008);
    pulse(1'b0);
    rdc("seed ones", 8'h89, 16'h03FF);
    wr(8'h80, 16'h4008);
    pulse(1'b0);
    rdc("seed zeros", 8'h89, 16'h0000);
    $display("test auto done");
  endtask
  task t_err;
    logic [39:0] w;
    wr(8'h80, 16'h4308);
    pulse(1'b0);
    send(10'd20, 4'hF, 1'b0, w);
    pulse(1'b1);
    rdc("cal error", 8'h88, 16'h000F);
    wr(8'h88, 16'h0000);
    rdc("cal error ro", 8'h88, 16'h000F);
    wr(8'h8B, 16'h0002);
    chk("err irq", 1, irq);
    wr(8'h8A, 16'h0002);
    rdc("status clear", 8'h8A, 16'h0000);
    pulse(1'b0);
    rdc("error cleared", 8'h88, 16'h0000);
    $display("test error done");
  endtask
  task t_narrow;
    int d;
    for (int m = 0; m < 2; m++) begin
      wr(8'h81, m ? 16'hE001 : 16'hC001);
      repeat (200) @(posedge clk_i);
      while (pix_ready !== 1'b1) @(posedge clk_i);
      d = 0;
      do begin @(posedge clk_i); d++; end while (pix_ready !== 1'b1 && d < 200);
      chk("slot length", 1, m ? (d >= 62 && d <= 66) : (d >= 78 && d <= 82));
    end
    $display("test narrow done");
  endtask

  task test_done;
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #2_000_000;
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    t_reset();
    t_lanes();
    t_manual();
    t_auto();
    t_err();
    t_narrow();
    test_done();
  end
endmodule // pix_out_path_tb
